// ---- core/pmts_pkg.sv ----
/*
 * Constants, mode codes and carrier structs for the power-mode and transmit sequencer.
 * Assumes a 250 MHz reference clock and a command front end that delivers decoded command bytes.
 */
package pmts_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int          CLK_FREQ_MHZ   = 250;
	localparam int          PWRUP_TIME_MS  = 10;
	localparam int          TX_TIME_MS     = 7000;
	localparam longint      PWRUP_CYC_L    = longint'(PWRUP_TIME_MS) * CLK_FREQ_MHZ * 1000;
	localparam longint      TX_CYC_L       = longint'(TX_TIME_MS) * CLK_FREQ_MHZ * 1000;
	localparam logic [31:0] PWRUP_CYCLES   = PWRUP_CYC_L[31:0];
	localparam logic [31:0] TX_CYCLES      = TX_CYC_L[31:0];

	// ----------------------------------------
	// Commands and sizes
	// ----------------------------------------
	localparam logic [7:0]  OP_SYS_RESET   = 8'h01;
	localparam logic [7:0]  OP_OFF_MODE    = 8'h05;
	localparam logic [7:0]  OP_WRITE_TXBUF = 8'h07;
	localparam logic [7:0]  OP_GET_STATUS  = 8'h0A;
	localparam logic [7:0]  OP_SEND_FRAME  = 8'h0D;
	localparam logic [7:0]  OP_GET_AUTH    = 8'h0F;
	localparam logic [7:0]  OP_WRITE_CONF  = 8'h11;
	localparam logic [7:0]  OP_GET_ID      = 8'h12;
	localparam logic [3:0]  TXBUF_DEPTH    = 4'hC;
	localparam int          WAKE_LOW_PINS  = 6;

	// ----------------------------------------
	// System configuration byte
	// ----------------------------------------
	localparam logic [7:0]  CFG_DEFAULT    = 8'hFF;
	localparam int          CFG_SUPPLY_BIT = 3;
	localparam logic [3:0]  CFG_BEAT       = 4'h2;

	typedef enum logic [2:0] {
		PMTS_OFF   = 3'b000,
		PMTS_RESET = 3'b001,
		PMTS_PWRUP = 3'b010,
		PMTS_IDLE  = 3'b011,
		PMTS_TX    = 3'b100
	} pmts_mode_e;

	typedef struct packed {
		logic       valid;
		logic [7:0] opcode;
		logic [3:0] index;
		logic [7:0] data;
	} pmts_cmd_s;

	typedef struct packed {
		logic         valid;
		logic [7:0]   opcode;
		logic [127:0] data;
	} pmts_rsp_s;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} pmts_tx_s;

endpackage

// ---- core/pmts_sequencer.sv ----
/*
 * Operating-mode sequencer: off, reset, power-up, idle and transmit, event line and configuration.
 * Assumes the pins arrive asynchronously and commands come decoded, one byte per beat, on i_ref_clk.
 */
`timescale 1ns/10ps
module pmts_sequencer #(
	parameter logic [31:0]  PWRUP_CYC = pmts_pkg::PWRUP_CYCLES,
	parameter logic [31:0]  TX_CYC    = pmts_pkg::TX_CYCLES,
	parameter logic [127:0] AUTH_CODE = 128'h0123456789ABCDEF0123456789ABCDEF, // Arbitrary value
	parameter logic [31:0]  ID_VALUE  = 32'h00C0FFEE                           // Arbitrary value
) (
	input  wire logic                                  i_ref_clk,
	input  wire logic                                  i_rst_b,
	input  wire logic                                  i_wake_pin_high,
	input  wire logic [pmts_pkg::WAKE_LOW_PINS-1:0]    i_wake_pins_low_group_n,
	input  wire logic                                  i_external_reset_n,
	input  wire pmts_pkg::pmts_cmd_s                   i_cmd,
	output logic                                       o_cmd_ready,
	output pmts_pkg::pmts_rsp_s                        o_rsp,
	output pmts_pkg::pmts_tx_s                         o_tx,
	output logic                                       o_event_line_n,
	output pmts_pkg::pmts_mode_e                       o_mode,
	output logic                                       o_power_en,
	output logic                                       o_core_reset,
	output logic [7:0]                                 o_config,
	output logic                                       o_supply_3v
);
	import pmts_pkg::*;

	localparam int         PINS     = WAKE_LOW_PINS + 2;
	localparam logic [7:0] PIN_IDLE = 8'hBF;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [PINS-1:0] pin_meta_reg;
	logic [PINS-1:0] pin_sync_reg;
	logic            wake_s;
	logic            ext_rst_s;

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_b)
		begin
			pin_meta_reg <= PIN_IDLE[PINS-1:0];
			pin_sync_reg <= PIN_IDLE[PINS-1:0];
		end
		else
		begin
			pin_meta_reg <= {i_external_reset_n, i_wake_pin_high, i_wake_pins_low_group_n};
			pin_sync_reg <= pin_meta_reg;
		end
	end

	assign wake_s    = pin_sync_reg[PINS-2] | ~(&pin_sync_reg[WAKE_LOW_PINS-1:0]);
	assign ext_rst_s = ~pin_sync_reg[PINS-1];

	// ----------------------------------------
	// Sequencer state
	// ----------------------------------------
	pmts_mode_e  mode_reg,  mode_next;
	logic [31:0] cnt_reg,   cnt_next;
	logic        event_reg, event_next;
	logic [7:0]  nv_reg,    nv_next;
	logic [7:0]  cfg_reg,   cfg_next;
	logic [3:0]  len_reg,   len_next;
	logic [3:0]  idx_reg,   idx_next;
	logic [7:0]  buf_reg  [TXBUF_DEPTH];
	logic [7:0]  buf_next [TXBUF_DEPTH];
	pmts_rsp_s   rsp_reg,   rsp_next;
	pmts_tx_s    tx_reg,    tx_next;
	logic        cmd_ok;
	logic        ev_set;
	logic        ev_clr;

	// Commands only count in idle and transmit; nothing is even looked at while off
	assign cmd_ok = i_cmd.valid && (mode_reg == PMTS_IDLE || mode_reg == PMTS_TX);

	always_comb
	begin
		mode_next = mode_reg;
		cnt_next  = cnt_reg;
		nv_next   = nv_reg;
		cfg_next  = cfg_reg;
		len_next  = len_reg;
		idx_next  = idx_reg;
		buf_next  = buf_reg;
		rsp_next  = '0;
		tx_next   = '0;
		ev_set    = 1'b0;
		ev_clr    = 1'b0;
		case (mode_reg)
			PMTS_OFF:
			begin
				cnt_next = '0;
				if (wake_s)
					mode_next = PMTS_RESET;
			end
			PMTS_RESET:
			begin
				cnt_next = '0;
				cfg_next = nv_reg;
				len_next = '0;
				ev_clr   = 1'b1;
				if (!ext_rst_s)
					mode_next = PMTS_PWRUP;
			end
			PMTS_PWRUP:
			begin
				if (ext_rst_s)
					mode_next = PMTS_RESET;
				else if (cnt_reg == PWRUP_CYC - 32'h1)
				begin
					mode_next = PMTS_IDLE;
					ev_set    = 1'b1;
				end
				else
					cnt_next = cnt_reg + 32'h1;
			end
			PMTS_IDLE, PMTS_TX:
			begin
				if (ext_rst_s)
					mode_next = PMTS_RESET;
				else
				begin
					if (mode_reg == PMTS_TX)
					begin
						// Payload bytes go out back to back, then the frame timer runs out
						if (idx_reg < len_reg)
						begin
							tx_next  = '{valid: 1'b1, data: buf_reg[idx_reg]};
							idx_next = idx_reg + 4'h1;
						end
						if (cnt_reg == TX_CYC - 32'h1)
						begin
							mode_next = PMTS_IDLE;
							ev_set    = 1'b1;
						end
						else
							cnt_next = cnt_reg + 32'h1;
					end
					if (cmd_ok)
					begin
						case (i_cmd.opcode)
							OP_SYS_RESET: mode_next = PMTS_RESET;
							OP_GET_STATUS:
							begin
								rsp_next = '{valid: 1'b1, opcode: OP_GET_STATUS,
									data: {120'h0, mode_reg, event_reg, len_reg}};
								ev_clr   = 1'b1;
							end
							OP_GET_AUTH: rsp_next = '{valid: 1'b1, opcode: OP_GET_AUTH, data: AUTH_CODE};
							OP_GET_ID:  rsp_next = '{valid: 1'b1, opcode: OP_GET_ID, data: {96'h0, ID_VALUE}};
							default:
							begin
								// Off, loading, send and configuration commands are ignored while a frame is being sent
								if (mode_reg == PMTS_IDLE)
								begin
									case (i_cmd.opcode)
										OP_OFF_MODE: mode_next = PMTS_OFF;
										OP_WRITE_TXBUF:
										begin
											// Bytes past the twelfth are dropped, not wrapped
											if (i_cmd.index < TXBUF_DEPTH)
											begin
												buf_next[i_cmd.index] = i_cmd.data;
												if (i_cmd.index >= len_reg)
													len_next = i_cmd.index + 4'h1;
											end
										end
										OP_SEND_FRAME:
										begin
											mode_next = PMTS_TX;
											cnt_next  = '0;
											idx_next  = '0;
										end
										OP_WRITE_CONF:
										begin
											if (i_cmd.index == CFG_BEAT)
											begin
												nv_next  = i_cmd.data;
												cfg_next = i_cmd.data;
											end
										end
										default: ;
									endcase
								end
							end
						endcase
					end
				end
			end
			default: mode_next = PMTS_OFF;
		endcase
		// A new event beats a status read landing in the same cycle
		event_next = (event_reg & ~ev_clr) | ev_set;
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_b)
		begin
			mode_reg  <= PMTS_OFF;
			cnt_reg   <= '0;
			event_reg <= 1'b0;
			nv_reg    <= CFG_DEFAULT;
			cfg_reg   <= CFG_DEFAULT;
			len_reg   <= '0;
			idx_reg   <= '0;
			buf_reg   <= '{default: 8'h00};
			rsp_reg   <= '0;
			tx_reg    <= '0;
		end
		else
		begin
			mode_reg  <= mode_next;
			cnt_reg   <= cnt_next;
			event_reg <= event_next;
			nv_reg    <= nv_next;
			cfg_reg   <= cfg_next;
			len_reg   <= len_next;
			idx_reg   <= idx_next;
			buf_reg   <= buf_next;
			rsp_reg   <= rsp_next;
			tx_reg    <= tx_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign o_cmd_ready    = (mode_reg == PMTS_IDLE) || (mode_reg == PMTS_TX);
	assign o_rsp          = rsp_reg;
	assign o_tx           = tx_reg;
	assign o_event_line_n = ~event_reg;
	assign o_mode         = mode_reg;
	assign o_power_en     = (mode_reg != PMTS_OFF);
	assign o_core_reset   = (mode_reg == PMTS_RESET);
	assign o_config       = cfg_reg;
	assign o_supply_3v    = cfg_reg[CFG_SUPPLY_BIT];

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);

	AST_POWER_ON_OFF: assert property ($past(i_rst_b) == 1'b0 |-> (o_mode == PMTS_OFF) && !o_power_en)
		else $error("Not off and unpowered after supply reset");
	AST_OFF_SILENT: assert property (o_mode == PMTS_OFF |=> !o_rsp.valid && !o_cmd_ready)
		else $error("Reply or ready while off");
	AST_OFF_IGNORES_RESET: assert property (o_mode == PMTS_OFF && !wake_s |=> o_mode == PMTS_OFF)
		else $error("Left off mode without a wake pin");
	AST_WAKE_STARTS: assert property (o_mode == PMTS_OFF && wake_s |=> o_core_reset && o_power_en)
		else $error("Wake pin did not start the reset");
	AST_RESET_HELD: assert property (o_mode == PMTS_RESET && ext_rst_s |=> o_mode == PMTS_RESET)
		else $error("Left reset while external reset held");
	AST_PWRUP_EVENT: assert property (o_mode == PMTS_IDLE && $past(o_mode) == PMTS_PWRUP |-> !o_event_line_n)
		else $error("Idle reached without the ready event");
	AST_SEND_ENTERS_TX: assert property (o_mode == PMTS_IDLE && !ext_rst_s && i_cmd.valid
		&& i_cmd.opcode == OP_SEND_FRAME |=> o_mode == PMTS_TX)
		else $error("Send frame did not enter transmit");
	AST_TX_END_EVENT: assert property (o_mode == PMTS_IDLE && $past(o_mode) == PMTS_TX |-> !o_event_line_n)
		else $error("Frame end without event");
	AST_STATUS_CLEARS: assert property (cmd_ok && !ext_rst_s && i_cmd.opcode == OP_GET_STATUS && !ev_set
		|=> o_event_line_n && o_rsp.valid)
		else $error("Status read did not clear the event");
	AST_IDLE_STAYS: assert property (o_mode == PMTS_IDLE && !wake_s && !ext_rst_s && !i_cmd.valid
		|=> o_mode == PMTS_IDLE)
		else $error("Idle lost after wake pins released");
	AST_CONF_APPLIED: assert property (o_mode == PMTS_PWRUP |-> o_config == nv_reg)
		else $error("Stored configuration not applied after reset");
	AST_AUTH_REPLY: assert property (cmd_ok && !ext_rst_s && i_cmd.opcode == OP_GET_AUTH
		|=> o_rsp.valid && o_rsp.data == AUTH_CODE)
		else $error("Authorization code reply wrong");

	COV_WAKE_TO_IDLE: cover property (o_mode == PMTS_PWRUP ##1 o_mode == PMTS_IDLE);
	COV_FRAME_DONE:   cover property (o_mode == PMTS_TX ##1 o_mode == PMTS_IDLE);
	COV_SHUTDOWN:     cover property (o_mode == PMTS_IDLE ##1 o_mode == PMTS_OFF);
	COV_SET_BEATS_CLR: cover property (ev_set && ev_clr);

endmodule

// ---- sim/pmts_host_model.sv ----
/*
 * Host-side model: drives the wake pins, the external reset and decoded command beats.
 * Assumes the bench calls its tasks hierarchically; every change lands on a falling edge.
 */
`timescale 1ns/10ps
module pmts_host_model #(
	parameter int HOLD_CYC = 2500
) (
	input  wire logic                               i_ref_clk,
	output pmts_pkg::pmts_cmd_s                     o_cmd,
	output logic                                    o_wake_pin_high,
	output logic [pmts_pkg::WAKE_LOW_PINS-1:0]      o_wake_pins_low_group_n,
	output logic                                    o_external_reset_n
);
	import pmts_pkg::*;

	initial
	begin
		o_cmd                   = '0;
		o_wake_pin_high         = 1'b0;
		o_wake_pins_low_group_n = '1;
		o_external_reset_n      = 1'b1;
	end

	// One beat; valid drops a cycle later so the caller may chain calls
	task automatic send(input logic [7:0] op, input logic [3:0] idx, input logic [7:0] dat);
		@(negedge i_ref_clk);
		o_cmd = '{valid: 1'b1, opcode: op, index: idx, data: dat};
		@(negedge i_ref_clk);
		o_cmd.valid = 1'b0;
	endtask

	// Activation is held for the whole hold time before anything else moves
	task automatic pins(input logic hi, input logic [5:0] lo_n, input logic rst_n, input int hold);
		@(negedge i_ref_clk);
		o_wake_pin_high         = hi;
		o_wake_pins_low_group_n = lo_n;
		o_external_reset_n      = rst_n;
		repeat (hold) @(negedge i_ref_clk);
	endtask
endmodule

// ---- sim/tb_top.sv ----
/*
 * Self-checking bench for the mode sequencer: wake, then rows of plain commands, transmit and shutdown.
 * Assumes short power-up and transmit counts; the host model supplies all pin and command stimulus.
 */
`timescale 1ns/10ps
module tb_top;
	import pmts_pkg::*;

	localparam logic [31:0]  PW   = 32'h14;
	localparam logic [31:0]  TXC  = 32'h28;
	localparam logic [127:0] AUTH = 128'h5A5A1234C3C3ABCD0F0F9876E1E14321; // Arbitrary value
	localparam logic [31:0]  ID   = 32'h1357ACE0;                          // Arbitrary value

	typedef struct packed {
		logic [7:0]   op;
		logic [127:0] mask;
		logic [127:0] exp;
		logic         ev_n;
	} pmts_row_s;

	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	pmts_cmd_s   cmd;
	logic        wk_hi;
	logic [5:0]  wk_lo_n;
	logic        ext_n;
	logic        rdy;
	pmts_rsp_s   rsp;
	pmts_tx_s    tx;
	logic        ev_n;
	pmts_mode_e  mode;
	logic        pwr;
	logic        core_rst;
	logic [7:0]  cfg;
	logic        s3v;
	logic [7:0]  got [16];
	int          n_tx = 0;
	int          n;
	int          n_mismatch = 0;
	int          comparisons = 0;
	pmts_row_s   rows [4] = '{
		'{8'h0A, 128'hFF, 128'h70, 1'b1},
		'{8'h0A, 128'hFF, 128'h60, 1'b1},
		'{8'h0F, '1, AUTH, 1'b1},
		'{8'h12, 128'hFFFFFFFF, {96'h0, ID}, 1'b1}};

	always #2 clk = ~clk;

	pmts_host_model host (
		.i_ref_clk               (clk),
		.o_cmd                   (cmd),
		.o_wake_pin_high         (wk_hi),
		.o_wake_pins_low_group_n (wk_lo_n),
		.o_external_reset_n      (ext_n)
	);

	pmts_sequencer #(.PWRUP_CYC(PW), .TX_CYC(TXC), .AUTH_CODE(AUTH), .ID_VALUE(ID)) uut (
		.i_ref_clk               (clk),
		.i_rst_b                 (rst_b),
		.i_wake_pin_high         (wk_hi),
		.i_wake_pins_low_group_n (wk_lo_n),
		.i_external_reset_n      (ext_n),
		.i_cmd                   (cmd),
		.o_cmd_ready             (rdy),
		.o_rsp                   (rsp),
		.o_tx                    (tx),
		.o_event_line_n          (ev_n),
		.o_mode                  (mode),
		.o_power_en              (pwr),
		.o_core_reset            (core_rst),
		.o_config                (cfg),
		.o_supply_3v             (s3v)
	);

	// Payload bytes are captured mid-cycle, where they are settled
	always @(negedge clk)
	begin
		if (tx.valid === 1'b1 && n_tx < 16)
		begin
			got[n_tx] = tx.data;
			n_tx++;
		end
	end

	task automatic conclude();
		$display("Checks %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
		comparisons++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("BAD %s exp %0h got %0h", nm, e, g);
		end
	endtask

	// Bounded wait; n counts falling edges until the mode shows
	task automatic wait_mode(input pmts_mode_e m, input int lim, output int n);
		n = 0;
		while (mode !== m && n < lim)
		begin
			@(negedge clk);
			n++;
		end
		if (mode !== m)
		begin
			n_mismatch++;
			$display("BAD mode_wait exp %0h got %0h", m, mode);
			conclude();
		end
	endtask

	initial
	begin
		repeat (3) @(negedge clk);
		rst_b = 1'b1;
		chk("mode", PMTS_OFF, mode);
		chk("power", 1'b0, pwr);
		chk("event", 1'b1, ev_n);
		chk("config", 8'hFF, cfg);
		host.send(OP_GET_STATUS, 4'h0, 8'h00);
		chk("rsp_valid", 1'b0, rsp.valid);
		chk("ready", 1'b0, rdy);
		host.pins(1'b0, 6'h3F, 1'b0, 2500);
		chk("mode", PMTS_OFF, mode);
		host.send(OP_SYS_RESET, 4'h0, 8'h00);
		chk("mode", PMTS_OFF, mode);
		host.pins(1'b0, 6'h3E, 1'b0, 2500);
		chk("mode", PMTS_RESET, mode);
		chk("core_reset", 1'b1, core_rst);
		host.pins(1'b0, 6'h3E, 1'b1, 0);
		wait_mode(PMTS_PWRUP, 8, n);
		wait_mode(PMTS_IDLE, 100, n);
		chk("pwrup_cycles", PW, n);
		chk("event", 1'b0, ev_n);
		chk("ready", 1'b1, rdy);
		host.pins(1'b0, 6'h3F, 1'b1, 0);
		repeat (8) @(negedge clk);
		chk("mode", PMTS_IDLE, mode);
		foreach (rows[i])
		begin
			host.send(rows[i].op, 4'h0, 8'h00);
			chk("rsp_valid", 1'b1, rsp.valid);
			chk("rsp_opcode", rows[i].op, rsp.opcode);
			chk("rsp_data", rows[i].exp, rsp.data & rows[i].mask);
			chk("event", rows[i].ev_n, ev_n);
		end
		host.send(OP_WRITE_CONF, 4'h2, 8'hF7);
		chk("config", 8'hF7, cfg);
		chk("supply_3v", 1'b0, s3v);
		host.send(OP_WRITE_CONF, 4'h0, 8'h00);
		chk("config", 8'hF7, cfg);
		host.send(OP_SYS_RESET, 4'h0, 8'h00);
		chk("mode", PMTS_RESET, mode);
		wait_mode(PMTS_IDLE, 100, n);
		chk("config", 8'hF7, cfg);
		host.send(OP_GET_STATUS, 4'h0, 8'h00);
		for (int i = 0; i < 13; i++)
			host.send(OP_WRITE_TXBUF, i[3:0], 8'hA0 + i[7:0]);
		host.send(OP_GET_STATUS, 4'h0, 8'h00);
		chk("status", 8'h6C, rsp.data[7:0]);
		n_tx = 0;
		host.send(OP_SEND_FRAME, 4'h0, 8'h00);
		chk("mode", PMTS_TX, mode);
		wait_mode(PMTS_IDLE, 200, n);
		chk("tx_cycles", TXC, n);
		chk("event", 1'b0, ev_n);
		chk("tx_count", 12, n_tx);
		for (int i = 0; i < 12; i++)
			chk("tx_byte", 8'hA0 + i[7:0], got[i]);
		host.send(OP_GET_STATUS, 4'h0, 8'h00);
		chk("event", 1'b1, ev_n);
		// External reset while powered sends the part back through power-up
		host.pins(1'b0, 6'h3F, 1'b0, 2500);
		chk("mode", PMTS_RESET, mode);
		chk("core_reset", 1'b1, core_rst);
		host.pins(1'b0, 6'h3F, 1'b1, 0);
		wait_mode(PMTS_IDLE, 100, n);
		chk("event", 1'b0, ev_n);
		host.send(OP_GET_STATUS, 4'h0, 8'h00);
		chk("event", 1'b1, ev_n);
		host.send(OP_OFF_MODE, 4'h0, 8'h00);
		chk("mode", PMTS_OFF, mode);
		chk("power", 1'b0, pwr);
		conclude();
	end
endmodule
